/* core/rcf_stages.sv */
// Eight rate-of-change-of-frequency protection stages with register port.
`timescale 1ns/10ps
module rcf_stages
    import rcf_pkg::*;
#(
    parameter int TICK_CYC  = TICK_CYC_DEF,
    parameter int STAMP_CYC = STAMP_CYC_DEF
)(
    input  wire logic                     core_clk,
    input  wire logic                     rst_n,
    input  wire logic [11:0]              reg_addr,
    input  wire logic [31:0]              reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [31:0]              reg_rdata,
    input  wire logic [NREF-1:0][SLW-1:0] meas_slope,
    input  wire logic [NREF-1:0]          meas_falling,
    input  wire logic [NREF-1:0][FQW-1:0] meas_freq,
    input  wire logic                     block_in,
    output logic      [NSTG-1:0]          start_o,
    output logic      [NSTG-1:0]          trip_o,
    output logic      [NSTG-1:0]          blocked_o,
    output logic      [NKIND*NSTG-1:0]    evt_on,
    output logic      [NKIND*NSTG-1:0]    evt_off,
    output logic      [31:0]              evt_stamp
);
    localparam int NE = NKIND * NSTG;

    // Elaboration check of the divider counts.
    if (TICK_CYC < 2 || STAMP_CYC < 2)
    begin : g_bad
        $error("Divider counts must be at least two.");
    end

    typedef struct packed {
        rcf_cfg_s [NGRP*NSTG-1:0]         grp;
        logic [NSTG-1:0][1:0]             en;
        logic [NSTG-1:0][1:0]             frc;
        logic [FQW-1:0]                   ceil;
        logic [1:0]                       ref_sel;
        logic [2:0]                       agrp;
        logic                             frc_en;
        logic [31:0]                      tdiv;
        logic [31:0]                      mdiv;
        logic [31:0]                      ms;
        logic                             b1;
        logic                             b2;
        logic [NSTG-1:0]                  pu;
        rcf_state_e [NSTG-1:0]            st;
        logic [NSTG-1:0][OTW-1:0]         tmr;
        logic [NSTG-1:0]                  sta;
        logic [NSTG-1:0]                  trp;
        logic [NSTG-1:0]                  blk;
        logic [NE-1:0]                    on;
        logic [NE-1:0]                    off;
        logic [31:0]                      stamp;
        logic [NE-1:0][CNW-1:0]           cnt;
        logic [PRE_TICKS-1:0][SLW-1:0]    hsl;
        logic [PRE_TICKS-1:0][FQW-1:0]    hfq;
        rcf_rec_s [NREC-1:0]              rec;
        logic [3:0]                       wp;
        logic [31:0]                      rdata;
    } rcf_state_s;

    rcf_state_s r_reg;
    rcf_state_s r_next;

    // Selected measurement and derived conditions.
    logic [1:0]     ref_idx;
    logic [SLW-1:0] sl;
    logic           fall;
    logic [FQW-1:0] fq;
    logic           tick;
    logic           ceil_hit;

    // Frequency reference selection; code 3 falls back to the first reference.
    always_comb
    begin
        ref_idx  = (r_reg.ref_sel < 2'(NREF)) ? r_reg.ref_sel : 2'h0;
        sl       = meas_slope[ref_idx];
        fall     = meas_falling[ref_idx];
        fq       = meas_freq[ref_idx];
        tick     = (r_reg.tdiv == 32'(TICK_CYC - 1));
        ceil_hit = sl > SLW'(r_reg.ceil);
    end

    // Whole next-state function: bus, dividers, stages, events, records.
    always_comb
    begin
        rcf_cfg_s        c;
        logic            act;
        logic            dir_ok;
        logic            pu_now;
        logic [PUW-1:0]  rel;
        logic [OTW:0]    tnx;
        logic [NE-1:0]   nw;
        logic [NE-1:0]   old;
        logic            hit;
        logic [4:0]      hidx;
        logic [3:0]      ri;
        r_next   = r_reg;
        c        = '0;
        act      = 1'b0;
        dir_ok   = 1'b0;
        pu_now   = 1'b0;
        rel      = '0;
        tnx      = '0;
        nw       = '0;
        old      = '0;
        hit      = 1'b0;
        hidx     = '0;
        ri       = '0;
        r_next.on  = '0;
        r_next.off = '0;

        // Blocking input synchroniser.
        r_next.b1 = block_in;
        r_next.b2 = r_reg.b1;

        // Time base and 1 ms stamp counter.
        r_next.tdiv = tick ? 32'h0 : r_reg.tdiv + 32'h1;
        if (r_reg.mdiv == 32'(STAMP_CYC - 1))
        begin
            r_next.mdiv = 32'h0;
            r_next.ms   = r_reg.ms + 32'h1;
        end
        else
        begin
            r_next.mdiv = r_reg.mdiv + 32'h1;
        end

        // Register writes.
        if (reg_wr)
        begin
            if (reg_addr == A_CTRL)
            begin
                r_next.ref_sel = reg_wdata[CTRL_REF +: 2];
                r_next.agrp    = reg_wdata[CTRL_GRP +: 3];
                r_next.frc_en  = reg_wdata[CTRL_FRC];
            end
            if (reg_addr == A_CEIL)
                r_next.ceil = reg_wdata[FQW-1:0];
            if (reg_addr[11:5] == 7'h01)
            begin
                r_next.en[reg_addr[4:2]]  = reg_wdata[1:0];
                r_next.frc[reg_addr[4:2]] = reg_wdata[5:4];
            end
            if (reg_addr[11])
            begin
                ri = {1'b0, reg_addr[4:2]};
                unique case (ri)
                    4'(GF_MODE):
                    begin
                        r_next.grp[reg_addr[10:5]].used = reg_wdata[0];
                        r_next.grp[reg_addr[10:5]].mode = rcf_mode_e'(reg_wdata[2:1]);
                        r_next.grp[reg_addr[10:5]].gate = reg_wdata[3];
                        r_next.grp[reg_addr[10:5]].inst = reg_wdata[4];
                    end
                    4'(GF_PU):  r_next.grp[reg_addr[10:5]].pu  = reg_wdata[PUW-1:0];
                    4'(GF_FLO): r_next.grp[reg_addr[10:5]].flo = reg_wdata[FQW-1:0];
                    4'(GF_FHI): r_next.grp[reg_addr[10:5]].fhi = reg_wdata[FQW-1:0];
                    4'(GF_OT):  r_next.grp[reg_addr[10:5]].ot  = reg_wdata[OTW-1:0];
                    default:    r_next.grp[reg_addr[10:5]] = r_reg.grp[reg_addr[10:5]];
                endcase
            end
        end

        // Stage evaluation once per time-base tick.
        if (tick)
        begin
            r_next.hsl = {r_reg.hsl[PRE_TICKS-2:0], sl};
            r_next.hfq = {r_reg.hfq[PRE_TICKS-2:0], fq};
            for (int s = 0; s < NSTG; s++)
            begin
                c      = r_reg.grp[{r_reg.agrp, 3'(s)}];
                act    = (r_reg.en[s] == EN_ON) && c.used;
                // Direction and frequency gate.
                if (fall)
                    dir_ok = (c.mode == MODE_FALL || c.mode == MODE_BOTH)
                             && (!c.gate || fq < c.flo);
                else
                    dir_ok = (c.mode == MODE_RISE || c.mode == MODE_BOTH)
                             && (!c.gate || fq > c.fhi);
                rel    = (c.pu > HYST) ? c.pu - HYST : '0;
                pu_now = act && dir_ok && !ceil_hit
                         && (r_reg.pu[s] ? sl > SLW'(rel) : sl > SLW'(c.pu));
                r_next.pu[s] = pu_now;
                tnx = {1'b0, r_reg.tmr[s]} + 20'h1;
                if (act && ceil_hit)
                begin
                    r_next.st[s]  = ST_BLOCK;
                    r_next.tmr[s] = '0;
                end
                else if (!pu_now)
                begin
                    r_next.st[s]  = ST_IDLE;
                    r_next.tmr[s] = '0;
                end
                else
                begin
                    unique case (r_reg.st[s])
                        ST_IDLE:
                        begin
                            r_next.tmr[s] = '0;
                            if (r_reg.b2 && !r_reg.pu[s])
                                r_next.st[s] = ST_BLOCK;
                            else if (r_reg.b2)
                                r_next.st[s] = ST_IDLE;
                            else
                                r_next.st[s] = c.inst ? ST_TRIP : ST_START;
                        end
                        ST_START:
                        begin
                            if (r_reg.b2)
                            begin
                                r_next.st[s]  = ST_IDLE;
                                r_next.tmr[s] = '0;
                            end
                            else if (tnx >= {1'b0, c.ot})
                                r_next.st[s] = ST_TRIP;
                            else
                                r_next.tmr[s] = tnx[OTW-1:0];
                        end
                        ST_TRIP:
                            r_next.st[s] = r_reg.b2 ? ST_IDLE : ST_TRIP;
                        ST_BLOCK:
                            r_next.st[s] = ST_BLOCK;
                    endcase
                end
                // Outputs, forced when global forcing is on.
                if (r_reg.frc_en)
                begin
                    r_next.sta[s] = r_reg.frc[s] == FRC_START
                                    || r_reg.frc[s] == FRC_TRIP;
                    r_next.trp[s] = r_reg.frc[s] == FRC_TRIP;
                    r_next.blk[s] = r_reg.frc[s] == FRC_BLOCKED;
                end
                else
                begin
                    r_next.sta[s] = r_next.st[s] == ST_START
                                    || r_next.st[s] == ST_TRIP;
                    r_next.trp[s] = r_next.st[s] == ST_TRIP;
                    r_next.blk[s] = r_next.st[s] == ST_BLOCK;
                end
            end
            // Edge events all share one stamp.
            nw  = {r_next.blk, r_next.trp, r_next.sta};
            old = {r_reg.blk, r_reg.trp, r_reg.sta};
            r_next.on    = nw & ~old;
            r_next.off   = ~nw & old;
            r_next.stamp = r_reg.ms;
            // Record the lowest start or trip on event of this tick.
            for (int e = 2 * NSTG - 1; e >= 0; e--)
            begin
                if (r_next.on[e])
                begin
                    hit  = 1'b1;
                    hidx = 5'(e);
                end
            end
            if (hit)
            begin
                r_next.rec[r_reg.wp] = '{stamp: r_reg.ms, grp: r_reg.agrp,
                                         stage: hidx[2:0], kind: {1'b0, hidx[3]} + 2'h1,
                                         pre_sl: r_reg.hsl[PRE_TICKS-1],
                                         pre_fq: r_reg.hfq[PRE_TICKS-1],
                                         flt_sl: sl, flt_fq: fq};
                r_next.wp = (r_reg.wp == 4'(NREC - 1)) ? 4'h0 : r_reg.wp + 4'h1;
            end
        end

        // Occurrence counters; an occurrence in the clear cycle still counts.
        for (int e = 0; e < NE; e++)
        begin
            if (reg_wr && reg_addr == A_CTRL && reg_wdata[CTRL_CLR])
                r_next.cnt[e] = '0;
            if (r_reg.on[e])
                r_next.cnt[e] = r_next.cnt[e] + CNW'(1);
        end

        // Register reads, answered one cycle later.
        r_next.rdata = 32'h0;
        if (reg_rd)
        begin
            if (reg_addr == A_CTRL)
                r_next.rdata = 32'({r_reg.frc_en, r_reg.agrp, r_reg.ref_sel});
            else if (reg_addr == A_CEIL)
                r_next.rdata = 32'(r_reg.ceil);
            else if (reg_addr == A_STATUS)
                r_next.rdata = {8'h00, r_reg.blk, r_reg.trp, r_reg.sta};
            else if (reg_addr == A_STAMP)
                r_next.rdata = r_reg.ms;
            else if (reg_addr[11:5] == 7'h01)
                r_next.rdata = 32'({r_reg.frc[reg_addr[4:2]], 2'h0, r_reg.en[reg_addr[4:2]]});
            else if (reg_addr[11:8] == 4'h1 && reg_addr[3:2] != 2'h3)
                r_next.rdata = 32'(r_reg.cnt[{reg_addr[3:2], reg_addr[6:4]}]);
            else if (reg_addr[11:10] == 2'h1 && reg_addr[9:5] < 5'(NREC))
            begin
                ri = reg_addr[8:5];
                unique case (reg_addr[4:2])
                    3'h0: r_next.rdata = r_reg.rec[ri].stamp;
                    3'h1: r_next.rdata = 32'({r_reg.rec[ri].grp, r_reg.rec[ri].stage,
                                              r_reg.rec[ri].kind});
                    3'h2: r_next.rdata = {3'h0, r_reg.rec[ri].pre_fq, r_reg.rec[ri].pre_sl};
                    3'h3: r_next.rdata = {3'h0, r_reg.rec[ri].flt_fq, r_reg.rec[ri].flt_sl};
                    default: r_next.rdata = 32'h0;
                endcase
            end
            else if (reg_addr[11])
            begin
                c = r_reg.grp[reg_addr[10:5]];
                unique case (reg_addr[4:2])
                    3'(GF_MODE): r_next.rdata = 32'({c.inst, c.gate, c.mode, c.used});
                    3'(GF_PU):   r_next.rdata = 32'(c.pu);
                    3'(GF_FLO):  r_next.rdata = 32'(c.flo);
                    3'(GF_FHI):  r_next.rdata = 32'(c.fhi);
                    3'(GF_OT):   r_next.rdata = 32'(c.ot);
                    default:     r_next.rdata = 32'h0;
                endcase
            end
        end
    end

    // State register with synchronous reset to documented defaults.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            r_reg      <= '0;
            r_reg.grp  <= {(NGRP*NSTG){rcf_cfg_s'{used: 1'b0, mode: MODE_RISE, gate: 1'b0,
                           inst: 1'b0, pu: PU_DEF, flo: F_LO_DEF, fhi: F_HI_DEF, ot: OT_DEF}}};
            r_reg.en   <= {NSTG{EN_OFF}};
            r_reg.ceil <= CEIL_DEF;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // Outputs straight from the state register.
    assign reg_rdata = r_reg.rdata;
    assign start_o   = r_reg.sta;
    assign trip_o    = r_reg.trp;
    assign blocked_o = r_reg.blk;
    assign evt_on    = r_reg.on;
    assign evt_off   = r_reg.off;
    assign evt_stamp = r_reg.stamp;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // Start and blocked never together while not forced.
    start_blk_excl_a: assert property (!r_reg.frc_en |-> ##0 (1'b1 ##1
        ($past(r_reg.frc_en) || (start_o & blocked_o) == '0)))
        else $error("Start and blocked asserted together.");

    // A stage left without start has no trip unless forced.
    trip_needs_start_a: assert property (!r_reg.frc_en |=>
        ($past(r_reg.frc_en) || (trip_o & ~start_o) == '0))
        else $error("Trip without start.");

    // Slope above the ceiling leaves no start after the tick.
    ceil_blocks_a: assert property (tick && ceil_hit && !r_reg.frc_en |=>
        (start_o & {NSTG{1'b1}}) == '0)
        else $error("Start despite slope above ceiling.");

    // Disabled stage 0 never starts or trips after a tick.
    stage_disabled_a: assert property (tick && !r_reg.frc_en && r_reg.en[0] != EN_ON |=>
        !start_o[0] && !trip_o[0])
        else $error("Disabled stage produced an output.");

    // On events mark exactly the rising outputs.
    event_edges_a: assert property ($changed({blocked_o, trip_o, start_o}) |->
        evt_on == ({blocked_o, trip_o, start_o} & ~$past({blocked_o, trip_o, start_o})))
        else $error("On events differ from output edges.");

    // Start and trip rising together share one event cycle and stamp.
    instant_pair_a: assert property ($rose(start_o[0]) && $rose(trip_o[0]) |->
        evt_on[0] && evt_on[NSTG] && evt_stamp == $past(r_reg.ms))
        else $error("Instant start and trip events split.");

    // Counter follows its event by one cycle.
    count_step_a: assert property (evt_on[0] && !(reg_wr && reg_addr == A_CTRL) |=>
        r_reg.cnt[0] == $past(r_reg.cnt[0]) + CNW'(1))
        else $error("Start counter did not step.");

    // Forced trip code shows start and trip after a tick.
    force_trip_a: assert property (tick && r_reg.frc_en && r_reg.frc[0] == FRC_TRIP |=>
        start_o[0] && trip_o[0] && !blocked_o[0])
        else $error("Forced trip not shown.");

    // Read data answer only in the cycle after a read.
    read_quiet_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("Read data without a read.");
endmodule

/* shared/rcf_pkg.sv */
// Shared constants and types of the slope protection stages.
package rcf_pkg;
    localparam int CLK_HZ        = 40_000_000;
    localparam int TICK_MS       = 5;
    localparam int TICK_CYC_DEF  = CLK_HZ / 1000 * TICK_MS;
    localparam int STAMP_MS      = 1;
    localparam int STAMP_CYC_DEF = CLK_HZ / 1000 * STAMP_MS;
    localparam int PRE_MS        = 20;
    localparam int PRE_TICKS     = PRE_MS / TICK_MS;
    localparam int NSTG          = 8;
    localparam int NGRP          = 8;
    localparam int NREF          = 3;
    localparam int NREC          = 12;
    localparam int NKIND         = 3;
    localparam int SLW           = 16;  // Slope in 0.01 Hz/s.
    localparam int FQW           = 13;  // Frequency in 0.01 Hz.
    localparam int PUW           = 10;
    localparam int OTW           = 19;  // Delay in 5 ms steps.
    localparam int CNW           = 16;
    localparam int HYST_MHZS     = 100;
    localparam logic [PUW-1:0] HYST     = PUW'(HYST_MHZS / 10);
    localparam logic [PUW-1:0] PU_DEF   = 10'h014;
    localparam logic [FQW-1:0] F_LO_DEF = 13'h1383;
    localparam logic [FQW-1:0] F_HI_DEF = 13'h13EC;
    localparam logic [OTW-1:0] OT_DEF   = 19'h00014;
    localparam logic [FQW-1:0] CEIL_DEF = 13'h07D0;
    localparam logic [1:0] EN_OFF = 2'h1;
    localparam logic [1:0] EN_ON  = 2'h2;
    typedef enum logic [1:0] {MODE_RISE = 2'h0, MODE_FALL = 2'h1, MODE_BOTH = 2'h2} rcf_mode_e;
    typedef enum logic [1:0] {FRC_NORMAL = 2'h0, FRC_START = 2'h1, FRC_TRIP = 2'h2,
                              FRC_BLOCKED = 2'h3} rcf_force_e;
    typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_START = 2'h1, ST_TRIP = 2'h3,
                              ST_BLOCK = 2'h2} rcf_state_e;
    localparam logic [11:0] A_CTRL   = 12'h000;
    localparam logic [11:0] A_CEIL   = 12'h004;
    localparam logic [11:0] A_STATUS = 12'h008;
    localparam logic [11:0] A_STAMP  = 12'h00C;
    localparam int CTRL_REF = 0;
    localparam int CTRL_GRP = 2;
    localparam int CTRL_FRC = 5;
    localparam int CTRL_CLR = 8;
    localparam int GF_MODE  = 0;
    localparam int GF_PU    = 1;
    localparam int GF_FLO   = 2;
    localparam int GF_FHI   = 3;
    localparam int GF_OT    = 4;
    typedef struct packed {
        logic            used;
        rcf_mode_e       mode;
        logic            gate;
        logic            inst;
        logic [PUW-1:0]  pu;
        logic [FQW-1:0]  flo;
        logic [FQW-1:0]  fhi;
        logic [OTW-1:0]  ot;
    } rcf_cfg_s;
    typedef struct packed {
        logic [31:0]     stamp;
        logic [2:0]      grp;
        logic [2:0]      stage;
        logic [1:0]      kind;
        logic [SLW-1:0]  pre_sl;
        logic [FQW-1:0]  pre_fq;
        logic [SLW-1:0]  flt_sl;
        logic [FQW-1:0]  flt_fq;
    } rcf_rec_s;
endpackage

/* verif/rcf_stages_bench.sv */
// Self-checking bench of the slope protection stages.
`timescale 1ns/10ps
`define CHK(n, e, v) begin tests_run++; if ((v) !== (e)) begin mismatches++; \
    $display("BAD %s exp %0h got %0h", n, e, v); end end
module rcf_stages_bench
    import rcf_pkg::*;
;
    logic                     core_clk, rst_n, reg_wr, reg_rd, block_in;
    logic [11:0]              reg_addr;
    logic [31:0]              reg_wdata, reg_rdata, evt_stamp, rdv;
    logic [NREF-1:0][SLW-1:0] meas_slope;
    logic [NREF-1:0]          meas_falling;
    logic [NREF-1:0][FQW-1:0] meas_freq;
    logic [NSTG-1:0]          start_o, trip_o, blocked_o;
    logic [NKIND*NSTG-1:0]    evt_on, evt_off;
    int                       mismatches, tests_run, cyc, off_cnt;

    rcf_stages #(.TICK_CYC(8), .STAMP_CYC(4)) uut (.core_clk(core_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .meas_slope(meas_slope), .meas_falling(meas_falling),
        .meas_freq(meas_freq), .block_in(block_in), .start_o(start_o), .trip_o(trip_o),
        .blocked_o(blocked_o), .evt_on(evt_on), .evt_off(evt_off), .evt_stamp(evt_stamp));

    // Clock of 25 ns period.
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // Hang guard: a run far past the expected length counts as a mismatch.
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            mismatches++;
            finish_test;
        end
    end

    // Counts trip off events of stage 0 from the value that stood in the last cycle.
    always @(posedge core_clk)
    begin
        if (evt_off[NSTG] === 1'b1)
            off_cnt++;
    end

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe.
    task automatic rd(input logic [11:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 rdv = reg_rdata;
    endtask

    // Waits whole measurement ticks of eight cycles.
    task automatic tk(input int n);
        repeat (n * 8) @(posedge core_clk);
        #1;
    endtask

    task automatic drv(input logic [SLW-1:0] sl, input logic fl, input logic [FQW-1:0] fq);
        @(posedge core_clk);
        meas_slope <= {NREF{sl}};
        meas_falling <= {NREF{fl}};
        meas_freq <= {NREF{fq}};
    endtask

    // Idles the input, then sets stage 0 of group 0 with a delay of four ticks.
    task automatic cfg(input logic [1:0] md, input logic gt, input logic ins);
        drv(16'h0000, 1'b0, 13'h1388);
        tk(3);
        wr(12'h020, 32'(EN_ON));
        wr(12'h800, {27'h0, ins, gt, md, 1'b1});
        wr(12'h810, 32'h0000_0004);
    endtask

    task automatic t_reset;
        rd(A_CEIL);
        `CHK("ceiling", 32'(CEIL_DEF), rdv)
        rd(12'h804);
        `CHK("pickup", 32'(PU_DEF), rdv)
        rd(12'h020);
        `CHK("enable", 32'(EN_OFF), rdv)
        rd(12'h7FC);
        `CHK("unmapped", 32'h0000_0000, rdv)
        $display("test reset done");
    endtask

    task automatic t_delay;
        cfg(MODE_RISE, 1'b0, 1'b0);
        drv(16'h001E, 1'b1, 13'h1388);
        tk(3);
        `CHK("fall in rise", 1'b0, start_o[0])
        drv(16'h001E, 1'b0, 13'h1388);
        tk(2);
        `CHK("start", 1'b1, start_o[0])
        `CHK("early trip", 1'b0, trip_o[0])
        tk(5);
        `CHK("trip", 1'b1, trip_o[0])
        drv(16'h000F, 1'b0, 13'h1388);
        tk(2);
        `CHK("hyst hold", 1'b1, start_o[0])
        drv(16'h0005, 1'b0, 13'h1388);
        tk(2);
        `CHK("release", 2'b00, {start_o[0], trip_o[0]})
        $display("test delay done");
    endtask

    task automatic t_gate;
        cfg(MODE_RISE, 1'b1, 1'b1);
        drv(16'h001E, 1'b0, 13'h1388);
        tk(3);
        `CHK("gate hi shut", 1'b0, trip_o[0])
        drv(16'h001E, 1'b0, 13'h1450);
        tk(3);
        `CHK("gate hi open", 2'b11, {start_o[0], trip_o[0]})
        cfg(MODE_BOTH, 1'b1, 1'b1);
        drv(16'h001E, 1'b1, 13'h1388);
        tk(3);
        `CHK("gate lo shut", 1'b0, trip_o[0])
        drv(16'h001E, 1'b1, 13'h1324);
        tk(3);
        `CHK("gate lo open", 1'b1, trip_o[0])
        $display("test gate done");
    endtask

    task automatic t_block;
        cfg(MODE_RISE, 1'b0, 1'b0);
        block_in <= 1'b1;
        wr(A_CTRL, 32'h0000_0100);
        drv(16'h001E, 1'b0, 13'h1388);
        tk(3);
        `CHK("blocked", 2'b10, {blocked_o[0], start_o[0]})
        block_in <= 1'b0;
        cfg(MODE_RISE, 1'b0, 1'b0);
        drv(16'h0834, 1'b0, 13'h1388);
        tk(3);
        `CHK("ceiling", 2'b10, {blocked_o[0], start_o[0]})
        rd(A_STATUS);
        `CHK("status", 32'h0001_0000, rdv)
        drv(16'h0000, 1'b0, 13'h1388);
        tk(3);
        rd(12'h108);
        `CHK("blk count", 32'h0000_0002, rdv)
        wr(A_CTRL, 32'h0000_0100);
        rd(12'h108);
        `CHK("count clear", 32'h0000_0000, rdv)
        $display("test block done");
    endtask

    // Records, forcing, then reference and group selection on stage 0.
    task automatic t_select;
        int n;
        rd(12'h404);
        `CHK("rec kind", 32'h0000_0001, rdv)
        rd(12'h40C);
        `CHK("rec fault", 32'h1388_001E, rdv)
        n = off_cnt;
        wr(12'h020, 32'h0000_0021);
        wr(A_CTRL, 32'h0000_0020);
        tk(2);
        `CHK("force trip", 3'b011, {blocked_o[0], trip_o[0], start_o[0]})
        wr(12'h020, 32'h0000_0031);
        tk(2);
        `CHK("force block", 3'b100, {blocked_o[0], trip_o[0], start_o[0]})
        `CHK("trip off evt", 1, off_cnt - n)
        wr(12'h020, 32'(EN_ON));
        wr(12'h900, 32'h0000_0011);
        wr(A_CTRL, 32'h0000_0006);
        @(posedge core_clk);
        meas_slope <= {16'h001E, 32'h0};
        tk(2);
        `CHK("ref grp trip", 2'b11, {start_o[0], trip_o[0]})
        @(posedge core_clk);
        meas_slope <= {32'h0, 16'h001E};
        tk(2);
        `CHK("ref other", 2'b00, {start_o[0], trip_o[0]})
        $display("test select done");
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Main sequence: reset for three cycles, then each test in turn.
    initial
    begin
        {rst_n, reg_wr, reg_rd, block_in, reg_addr, reg_wdata} = '0;
        {meas_slope, meas_falling, meas_freq} = '0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset;
        t_delay;
        t_gate;
        t_block;
        t_select;
        finish_test;
    end
endmodule
